// ==== include/itpc_pkg.sv ====
// Constants, register map and state encoding of the inductive transmitter control.
// Assumes a single 100 MHz system clock shared by every module of the block.
package itpc_pkg;

  // Clock rate
  localparam int CLK_MHZ = 100;

  // Phase accumulator: one drive period is PHASE_MOD counts, the bridge
  // frequency in Hz is added every clock
  localparam logic [26:0] PHASE_MOD = 27'h5f5e100;
  localparam logic [26:0] PHASE_HALF = 27'h2faf080;

  // Switching frequency in Hz
  localparam logic [17:0] FREQ_MIN = 18'h1adb0;
  localparam logic [17:0] FREQ_MAX = 18'h320c8;
  localparam logic [17:0] PROBE_FREQ = 18'h25d78;
  localparam logic [17:0] PROBE_FREQ_TOL = 18'h03a98;
  localparam logic [17:0] PROBE_FREQ_LOW = PROBE_FREQ - PROBE_FREQ_TOL;
  localparam logic [17:0] PROBE_STEP = 18'h01388;

  // Duty cycle in units of 0.01 percent of the period
  localparam logic [12:0] DUTY_MIN = 13'h00c8;
  localparam logic [12:0] DUTY_MAX = 13'h1388;
  localparam logic [12:0] DUTY_PROBE = 13'h0bb8;
  localparam logic [13:0] DUTY_PHASE_STEP = 14'h2710;

  // Loop output limit and scaling divisors (frequency 1 Hz, duty 0.1 unit)
  localparam logic signed [17:0] LOOP_OUTPUT_LIMIT = 18'sh04e20;
  localparam int FREQ_SCALE_DIV = 1;
  localparam int DUTY_SCALE_DIV = 10;

  // Dead time between high and low switches of one leg, rounded up
  localparam int DEAD_TIME_NS = 50;
  localparam logic [3:0] DEAD_CYC = 4'((DEAD_TIME_NS * CLK_MHZ + 999) / 1000);

  // Probe answer window and power-off gap, rounded down
  localparam int PROBE_WAIT_MS = 70;
  localparam int OFF_GAP_MS = 10;
  localparam int PROBE_WAIT_CYC_DEF = PROBE_WAIT_MS * CLK_MHZ * 1000;
  localparam int OFF_GAP_CYC_DEF = OFF_GAP_MS * CLK_MHZ * 1000;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_THRESH = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_FREQ = 8'h10;
  localparam logic [7:0] REG_DUTY = 8'h14;
  localparam logic [7:0] REG_CURRENT = 8'h18;

  // Control field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_RETRY = 1;
  localparam int CTRL_FREQ_ONLY = 2;

  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] TARGET_RST = 16'h01f4;
  localparam logic [7:0] THRESH_RST = 8'h40;

  // Sequencer states, Gray along idle, probe, transfer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROBE = 2'b01,
    ST_XFER = 2'b11,
    ST_GAP = 2'b10
  } itpc_state_t;

endpackage

// ==== logic/itpc_leg_drive.sv ====
// One bridge leg: complementary high and low gate signals with dead time.
// Assumes the wanted level is synchronous to sys_clk_i.
`timescale 1ns/10ps
module itpc_leg_drive import itpc_pkg::*; #(
  parameter logic [3:0] DEAD = DEAD_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic want_hi_i,
  output logic gate_hi_o,
  output logic gate_lo_o
);

  typedef struct packed {
    logic cur;
    logic [3:0] cnt;
    logic hi;
    logic lo;
  } itpc_leg_t;

  itpc_leg_t s;
  itpc_leg_t next_s;

  // Both switches open on every change, the new one closes DEAD plus one cycles later
  always_comb begin
    next_s = s;
    if (!enable_i) begin
      next_s.hi = 1'b0;
      next_s.lo = 1'b0;
      next_s.cnt = DEAD;
      next_s.cur = want_hi_i;
    end else if (want_hi_i != s.cur) begin
      next_s.cur = want_hi_i;
      next_s.cnt = DEAD; // RQ14
      next_s.hi = 1'b0;
      next_s.lo = 1'b0;
    end else if (s.cnt != 4'h0) begin
      next_s.cnt = s.cnt - 4'h1;
    end else begin
      next_s.hi = s.cur; // RQ14
      next_s.lo = ~s.cur; // RQ14
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s <= '{cur: 1'b0, cnt: DEAD, hi: 1'b0, lo: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign gate_hi_o = s.hi;
  assign gate_lo_o = s.lo;

endmodule // itpc_leg_drive

// ==== logic/itpc_loop_step.sv ====
// One proportional loop step: limits the error, scales it, clamps the result.
// Assumes the caller applies value_o only on a new current sample.
`timescale 1ns/10ps
module itpc_loop_step import itpc_pkg::*; #(
  parameter int W = 18,
  parameter logic [W-1:0] VMIN = '0,
  parameter logic [W-1:0] VMAX = '1,
  parameter bit INVERT = 1'b0,
  parameter int DIV = 1
) (
  input wire logic signed [17:0] err_i,
  input wire logic [W-1:0] value_i,
  output logic [W-1:0] value_o,
  output logic sat_o
);

  localparam logic signed [17:0] DIVS = 18'(DIV);

  logic signed [17:0] pid;
  logic signed [17:0] delta;
  logic signed [W+1:0] sum;

  // Unity gain, no integral or derivative part, output limited
  always_comb begin
    if (err_i > LOOP_OUTPUT_LIMIT) begin
      pid = LOOP_OUTPUT_LIMIT; // RQ12 RQ13
    end else if (err_i < -LOOP_OUTPUT_LIMIT) begin
      pid = -LOOP_OUTPUT_LIMIT; // RQ12 RQ13
    end else begin
      pid = err_i;
    end
    delta = INVERT ? -(pid / DIVS) : pid / DIVS;
    sum = $signed({2'b00, value_i}) + (W+2)'(delta);
    sat_o = 1'b0;
    if (sum < $signed({2'b00, VMIN})) begin
      value_o = VMIN; // RQ15
      sat_o = 1'b1;
    end else if (sum > $signed({2'b00, VMAX})) begin
      value_o = VMAX; // RQ15
      sat_o = 1'b1;
    end else begin
      value_o = sum[W-1:0];
    end
  end

endmodule // itpc_loop_step

// ==== logic/itpc_top.sv ====
// Inductive transmitter control: probe sequencing, proportional power loop
// and full-bridge drive generation, with a small register port.
// Assumes all inputs synchronous to sys_clk_i and a fixed bridge supply.
`timescale 1ns/10ps
// Behaviour
// RQ1: Frequency held within 110 to 205 kHz
// RQ2: Duty held within 2 to 50 percent
// RQ3: Less power means higher frequency, lower duty
// RQ4: Frequency settable in 1 Hz steps
// RQ5: Probe starts at 155 kHz
// RQ6: Probe drives 30 percent duty
// RQ7: No strength report removes the power
// RQ8: Optional retries at lower frequencies until accepted; the code gives up after the 140 kHz probe and flags a probe failure
// RQ9: Transfer regulated by loop on frequency, duty
// RQ10: Duty is adjusted first, frequency second
// RQ11: Coil current taken in 1 mA units
// RQ12: Frequency loop: unity gain, limit, 1 Hz
// RQ13: Duty loop: unity gain, limit, minus 0.1
// RQ14: Complementary leg drive with dead time
// RQ15: New commands clamped before reaching the bridge
module itpc_top import itpc_pkg::*; #(
  parameter int PROBE_WAIT_CYC = PROBE_WAIT_CYC_DEF,
  parameter int OFF_GAP_CYC = OFF_GAP_CYC_DEF
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic strength_valid_i,
  input wire logic [7:0] strength_i,
  input wire logic end_transfer_i,
  input wire logic current_valid_i,
  input wire logic [15:0] coil_current_i,
  output logic power_on_o,
  output logic gate_a_hi_o,
  output logic gate_a_lo_o,
  output logic gate_b_hi_o,
  output logic gate_b_lo_o,
  output logic [17:0] switching_frequency_o,
  output logic [12:0] duty_cycle_o
);

  typedef struct packed {
    itpc_state_t st;
    logic [31:0] tmr;
    logic enable;
    logic retry_en;
    logic freq_only;
    logic probe_fail;
    logic accepted;
    // Sticky loop clamp flags, cleared when a new probe starts
    logic duty_clamped;
    logic freq_clamped;
    logic [15:0] target;
    logic [7:0] thresh;
    logic [7:0] last_strength;
    logic [15:0] current;
    logic [3:0] probes;
    logic [17:0] probe_freq;
    logic [17:0] freq;
    logic [12:0] duty;
    logic [17:0] act_freq;
    logic [12:0] act_duty;
    logic [26:0] acc;
    logic bridge_on;
    logic [31:0] rdata;
  } itpc_top_t;

  itpc_top_t s;
  itpc_top_t next_s;

  localparam logic [31:0] PROBE_WAIT_LOAD = 32'(PROBE_WAIT_CYC);
  localparam logic [31:0] OFF_GAP_LOAD = 32'(OFF_GAP_CYC);

  logic signed [17:0] err;
  logic [17:0] freq_step;
  logic freq_sat;
  logic [12:0] duty_step;
  logic duty_sat;
  logic [27:0] acc_sum;
  logic wrap;
  logic [26:0] duty_phase;
  logic [26:0] acc_b;
  logic want_a;
  logic want_b;
  logic powered;

  // Loop error in mA: positive when the coil carries too much current
  // Measured minus target, so a positive error always asks for less power
  assign err = $signed({2'b00, coil_current_i}) - $signed({2'b00, s.target}); // RQ11

  // Both steps are worked out every cycle; the sequencer picks which one lands
  // Frequency step: excess current raises the frequency by 1 Hz per unit
  itpc_loop_step #(
    .W(18),
    .VMIN(FREQ_MIN),
    .VMAX(FREQ_MAX),
    .INVERT(1'b0),
    .DIV(FREQ_SCALE_DIV)
  ) u_freq_step (
    .err_i(err),
    .value_i(s.freq),
    .value_o(freq_step),
    .sat_o(freq_sat)
  );

  // Duty step: excess current lowers the duty by 0.1 unit per unit
  itpc_loop_step #(
    .W(13),
    .VMIN(DUTY_MIN),
    .VMAX(DUTY_MAX),
    .INVERT(1'b1),
    .DIV(DUTY_SCALE_DIV)
  ) u_duty_step (
    .err_i(err),
    .value_i(s.duty),
    .value_o(duty_step),
    .sat_o(duty_sat)
  );

  // Phase accumulator: adding the frequency in Hz each clock gives 1 Hz resolution
  // One period is PHASE_MOD over the frequency in clocks, so it follows the command
  assign acc_sum = {1'b0, s.acc} + {10'h000, s.act_freq}; // RQ4
  assign wrap = acc_sum >= {1'b0, PHASE_MOD};

  // Leg A conducts from phase zero, leg B half a period later, each for the duty
  // Widen before multiplying, so the product cannot wrap at the operand width
  assign duty_phase = 27'(s.act_duty) * 27'(DUTY_PHASE_STEP);
  assign acc_b = s.acc - PHASE_HALF;
  assign want_a = s.acc < duty_phase;
  assign want_b = (s.acc >= PHASE_HALF) && (acc_b < duty_phase);
  assign powered = (s.st == ST_PROBE) || (s.st == ST_XFER);

  // Next state: register port, sequencer, loop and drive timing
  always_comb begin
    next_s = s;
    // Read data fall back to zero, so the port shows nothing outside a read
    next_s.rdata = 32'h0000_0000;
    next_s.bridge_on = powered;

    // Register writes
    // Read-only and unmapped offsets fall to the default and are ignored
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL: begin
          next_s.enable = reg_wdata_i[CTRL_ENABLE];
          next_s.retry_en = reg_wdata_i[CTRL_RETRY];
          next_s.freq_only = reg_wdata_i[CTRL_FREQ_ONLY];
          if (!reg_wdata_i[CTRL_ENABLE]) begin
            next_s.probe_fail = 1'b0;
            next_s.accepted = 1'b0;
          end
        end
        REG_TARGET: next_s.target = reg_wdata_i[15:0];
        REG_THRESH: next_s.thresh = reg_wdata_i[7:0];
        default: ;
      endcase
    end

    // Register reads, data valid in the next cycle only
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL: next_s.rdata = {29'h0, s.freq_only, s.retry_en, s.enable};
        REG_TARGET: next_s.rdata = {16'h0000, s.target};
        REG_THRESH: next_s.rdata = {24'h000000, s.thresh};
        REG_STATUS: next_s.rdata = {12'h000, s.last_strength, s.probes, 1'b0, s.freq_clamped,
                                    s.duty_clamped, s.accepted, s.probe_fail, powered, s.st};
        REG_FREQ: next_s.rdata = {14'h0000, s.act_freq};
        REG_DUTY: next_s.rdata = {19'h00000, s.act_duty};
        REG_CURRENT: next_s.rdata = {16'h0000, s.current};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Latest coil current sample for software
    if (current_valid_i) begin
      next_s.current = coil_current_i; // RQ11
    end

    // Timer
    // The probe and gap states load it on entry, so no state ever needs to clear it
    if (s.tmr != 32'h0) begin
      next_s.tmr = s.tmr - 32'h1;
    end

    // Probe and transfer sequencing
    // Retries step down one probe step at a time and stop inside the probe window
    unique case (s.st)
      ST_IDLE: begin
        if (s.enable && !s.probe_fail) begin
          next_s.st = ST_PROBE;
          next_s.probe_freq = PROBE_FREQ;
          next_s.freq = PROBE_FREQ; // RQ5
          next_s.duty = DUTY_PROBE; // RQ6
          next_s.probes = 4'h1;
          next_s.tmr = PROBE_WAIT_LOAD;
          next_s.accepted = 1'b0;
          next_s.duty_clamped = 1'b0;
          next_s.freq_clamped = 1'b0;
        end
      end
      ST_PROBE: begin
        if (!s.enable) begin
          next_s.st = ST_IDLE;
        end else if (strength_valid_i) begin
          next_s.last_strength = strength_i;
          if (strength_i >= s.thresh) begin
            next_s.st = ST_XFER; // RQ8
            next_s.accepted = 1'b1;
          end else begin
            next_s.st = ST_GAP;
            next_s.tmr = OFF_GAP_LOAD;
          end
        end else if (s.tmr == 32'h0) begin
          next_s.st = ST_GAP; // RQ7
          next_s.tmr = OFF_GAP_LOAD;
        end
      end
      ST_GAP: begin
        if (!s.enable) begin
          next_s.st = ST_IDLE;
        end else if (s.tmr == 32'h0) begin
          if (s.retry_en && (s.probe_freq >= PROBE_FREQ_LOW + PROBE_STEP)) begin
            next_s.st = ST_PROBE; // RQ8
            next_s.probe_freq = s.probe_freq - PROBE_STEP;
            next_s.freq = s.probe_freq - PROBE_STEP; // RQ5
            next_s.duty = DUTY_PROBE; // RQ6
            next_s.probes = s.probes + 4'h1;
            next_s.tmr = PROBE_WAIT_LOAD;
          end else begin
            next_s.st = ST_IDLE; // RQ7
            next_s.probe_fail = 1'b1;
          end
        end
      end
      ST_XFER: begin
        if (!s.enable || end_transfer_i) begin
          next_s.st = ST_IDLE;
        end else if (current_valid_i) begin
          // Duty first; frequency only when the duty is pinned or selected
          if (s.freq_only) begin
            next_s.freq = freq_step; // RQ9 RQ12 RQ3
            next_s.freq_clamped = s.freq_clamped | freq_sat; // RQ15
          end else begin
            next_s.duty = duty_step; // RQ10 RQ13 RQ3
            next_s.duty_clamped = s.duty_clamped | duty_sat; // RQ15
            if (duty_sat) begin
              next_s.freq = freq_step; // RQ10 RQ9
              next_s.freq_clamped = s.freq_clamped | freq_sat; // RQ15
            end
          end
        end
      end
    endcase

    // Software clearing the enable sends the sequencer to idle in the next cycle, the bridge goes off a cycle after that
    // Placed after the sequencer, so it overrides any change of state in the same cycle
    if (reg_wr_i && (reg_addr_i == REG_CTRL) && !reg_wdata_i[CTRL_ENABLE]) begin
      next_s.st = ST_IDLE;
    end

    // A failure found in this cycle survives a clear in the same cycle
    if ((s.st == ST_GAP) && (next_s.st == ST_IDLE) && (s.tmr == 32'h0) && s.enable) begin
      next_s.probe_fail = !(s.retry_en && (s.probe_freq >= PROBE_FREQ_LOW + PROBE_STEP));
    end

    // New commands reach the bridge only at a period boundary
    // Holding them for a whole period keeps both half cycles alike
    if (!s.bridge_on) begin
      next_s.acc = 27'h0;
      next_s.act_freq = s.freq; // RQ1
      next_s.act_duty = s.duty; // RQ2
    end else if (wrap) begin
      next_s.acc = 27'(acc_sum - {1'b0, PHASE_MOD});
      next_s.act_freq = s.freq; // RQ1 RQ15
      next_s.act_duty = s.duty; // RQ2 RQ15
    end else begin
      next_s.acc = acc_sum[26:0];
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s <= '{
        st: ST_IDLE,
        tmr: 32'h0,
        enable: CTRL_RST[CTRL_ENABLE],
        retry_en: CTRL_RST[CTRL_RETRY],
        freq_only: CTRL_RST[CTRL_FREQ_ONLY],
        probe_fail: 1'b0,
        accepted: 1'b0,
        duty_clamped: 1'b0,
        freq_clamped: 1'b0,
        target: TARGET_RST,
        thresh: THRESH_RST,
        last_strength: 8'h00,
        current: 16'h0000,
        probes: 4'h0,
        probe_freq: PROBE_FREQ,
        freq: PROBE_FREQ,
        duty: DUTY_PROBE,
        act_freq: PROBE_FREQ,
        act_duty: DUTY_PROBE,
        acc: 27'h0,
        bridge_on: 1'b0,
        rdata: 32'h0
      };
    end else begin
      s <= next_s;
    end
  end

  // Both legs share one enable, so the whole bridge opens when power is removed
  // Bridge leg A
  itpc_leg_drive #(
    .DEAD(DEAD_CYC)
  ) u_leg_a (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(s.bridge_on),
    .want_hi_i(want_a),
    .gate_hi_o(gate_a_hi_o),
    .gate_lo_o(gate_a_lo_o)
  );

  // Bridge leg B, driven half a period later
  itpc_leg_drive #(
    .DEAD(DEAD_CYC)
  ) u_leg_b (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(s.bridge_on),
    .want_hi_i(want_b),
    .gate_hi_o(gate_b_hi_o),
    .gate_lo_o(gate_b_lo_o)
  );

  // Outputs
  assign reg_rdata_o = s.rdata;
  assign power_on_o = s.bridge_on;
  assign switching_frequency_o = s.act_freq;
  assign duty_cycle_o = s.act_duty;

endmodule // itpc_top

// ==== bench/itpc_asserts.sv ====
// Port checker of the transmitter control: ranges, gate drive, read port.
// Assumes it is bound into itpc_top and sees only its ports.
`timescale 1ns/10ps
module itpc_asserts import itpc_pkg::*; #(
  parameter int PROBE_WAIT_CYC = 200,
  parameter int OFF_GAP_CYC = 50
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic strength_valid_i,
  input wire logic [7:0] strength_i,
  input wire logic end_transfer_i,
  input wire logic current_valid_i,
  input wire logic [15:0] coil_current_i,
  input wire logic power_on_o,
  input wire logic gate_a_hi_o,
  input wire logic gate_a_lo_o,
  input wire logic gate_b_hi_o,
  input wire logic gate_b_lo_o,
  input wire logic [17:0] switching_frequency_o,
  input wire logic [12:0] duty_cycle_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Commanded values stay inside the allowed bands while driving
  a_freq_range: assert property (power_on_o |-> switching_frequency_o inside {[FREQ_MIN:FREQ_MAX]})
    else $error("frequency outside band while driving");
  a_duty_range: assert property (power_on_o |-> duty_cycle_o inside {[DUTY_MIN:DUTY_MAX]})
    else $error("duty outside band while driving");
  // First drive of a probe sits in the probe windows
  a_probe_freq: assert property ($rose(power_on_o) |-> switching_frequency_o inside {[18'h222e0:18'h29810]})
    else $error("probe frequency outside window");
  a_probe_duty: assert property ($rose(power_on_o) |-> duty_cycle_o inside {[13'h07d0:13'h0fa0]})
    else $error("probe duty outside window");
  // Never both switches of a leg, and a gap before the other side turns on
  a_leg_a_excl: assert property (!(gate_a_hi_o && gate_a_lo_o))
    else $error("leg a both switches on");
  a_leg_b_excl: assert property (!(gate_b_hi_o && gate_b_lo_o))
    else $error("leg b both switches on");
  a_dead_a: assert property ($fell(gate_a_lo_o) |-> !gate_a_hi_o [*4])
    else $error("leg a dead time too short");
  a_dead_b: assert property ($fell(gate_b_hi_o) |-> !gate_b_lo_o [*4])
    else $error("leg b dead time too short");
  // Power removed means a quiet bridge
  a_gates_off: assert property (!power_on_o && $past(!power_on_o) |-> !(gate_a_hi_o || gate_a_lo_o || gate_b_hi_o || gate_b_lo_o))
    else $error("gates active without power");
  // Read data only in the cycle after a read, frequency read matches output
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_rdata_freq: assert property ($past(reg_rd_i) && $past(reg_addr_i) == REG_FREQ |->
    reg_rdata_o == {14'h0, $past(switching_frequency_o)})
    else $error("frequency read differs from output");
endmodule // itpc_asserts

bind itpc_top itpc_asserts #(.PROBE_WAIT_CYC(PROBE_WAIT_CYC), .OFF_GAP_CYC(OFF_GAP_CYC)) itpc_asserts_inst (.*);

// ==== bench/itpc_coil_model.sv ====
// Model of bridge and coil: hands coil current samples, watches the gates.
// Assumes sample requests from the bench, synchronous to sys_clk_i.
`timescale 1ns/10ps
module itpc_coil_model (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sample_req_i,
  input wire logic [15:0] level_i,
  input wire logic gate_a_hi_i,
  input wire logic gate_a_lo_i,
  input wire logic gate_b_hi_i,
  input wire logic gate_b_lo_i,
  output logic current_valid_o,
  output logic [15:0] coil_current_o,
  output logic overlap_o
);
  // One-cycle sample; between samples the value lines toggle, not hold
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      current_valid_o <= 1'b0;
      coil_current_o <= 16'h0;
      overlap_o <= 1'b0;
    end else begin
      current_valid_o <= sample_req_i;
      coil_current_o <= sample_req_i ? level_i : ~coil_current_o;
      overlap_o <= overlap_o | (gate_a_hi_i & gate_a_lo_i) | (gate_b_hi_i & gate_b_lo_i);
    end
  end
endmodule // itpc_coil_model

// ==== bench/itpc_tb_top.sv ====
// Testbench of the transmitter control: register port, probe, retry, loop.
// Assumes short probe and gap counts and the coil model as far side.
`timescale 1ns/10ps
module itpc_tb_top import itpc_pkg::*;;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic strength_valid_i = 1'b0;
  logic [7:0] strength_i = 8'h0;
  logic end_transfer_i = 1'b0;
  logic sample_req = 1'b0;
  logic [15:0] level = 16'h0;
  logic [31:0] reg_rdata_o, d;
  logic power_on_o, gate_a_hi_o, gate_a_lo_o, gate_b_hi_o, gate_b_lo_o, current_valid_i, overlap;
  logic [15:0] coil_current_i;
  logic [17:0] switching_frequency_o;
  logic [12:0] duty_cycle_o;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  itpc_top #(.PROBE_WAIT_CYC(200), .OFF_GAP_CYC(50)) itpc_top_inst (.*);
  itpc_coil_model itpc_coil_model_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .sample_req_i(sample_req), .level_i(level), .gate_a_hi_i(gate_a_hi_o), .gate_a_lo_i(gate_a_lo_o),
    .gate_b_hi_i(gate_b_hi_o), .gate_b_lo_i(gate_b_lo_o), .current_valid_o(current_valid_i),
    .coil_current_o(coil_current_i), .overlap_o(overlap));

  // Clock and hang guard
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(name, d, exp);
  endtask

  // Waits for the power signal to reach a level, bounded
  task automatic wait_pwr(input logic want);
    int n;
    n = 0;
    while (power_on_o !== want && n < 400) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    #1 chk("power", {31'h0, power_on_o}, {31'h0, want});
  endtask

  task automatic report(input logic [7:0] v);
    @(posedge sys_clk_i);
    strength_valid_i <= 1'b1;
    strength_i <= v;
    @(posedge sys_clk_i);
    strength_valid_i <= 1'b0;
  endtask

  // One current sample, then the applied commands after the next wrap
  task automatic samp(input logic [15:0] cur, input logic [31:0] ef, input logic [31:0] ed);
    logic [30:0] prev;
    int n;
    prev = {switching_frequency_o, duty_cycle_o};
    @(posedge sys_clk_i);
    sample_req <= 1'b1;
    level <= cur;
    @(posedge sys_clk_i);
    sample_req <= 1'b0;
    n = 0;
    while ({switching_frequency_o, duty_cycle_o} === prev && n < 1500) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    #1 chk("frequency", {14'h0, switching_frequency_o}, ef);
    chk("duty", {19'h0, duty_cycle_o}, ed);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, refused write, unmapped read
    rchk("ctrl", REG_CTRL, 32'h0);
    rchk("target", REG_TARGET, 32'h1f4);
    rchk("thresh", REG_THRESH, 32'h40);
    wr(REG_TARGET, 32'hffff_0258);
    rchk("target wr", REG_TARGET, 32'h258);
    wr(REG_TARGET, 32'h1f4);
    wr(REG_THRESH, 32'h0000_0141);
    rchk("thresh wr", REG_THRESH, 32'h41);
    wr(REG_THRESH, 32'h40);
    wr(REG_FREQ, 32'h0);
    rchk("freq", REG_FREQ, 32'd155000);
    rchk("unmapped", 8'h1c, 32'h0);
    $display("test registers done");
    // Probe with no report, no retry
    wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("power", {31'h0, power_on_o}, 32'h1);
    chk("probe freq", {14'h0, switching_frequency_o}, 32'd155000);
    chk("probe duty", {19'h0, duty_cycle_o}, 32'd3000);
    wait_pwr(1'b0);
    repeat (60) @(posedge sys_clk_i);
    #1 chk("no retry", {31'h0, power_on_o}, 32'h0);
    rd(REG_STATUS);
    chk("probe fail", d & 32'h8, 32'h8);
    wr(REG_CTRL, 32'h0);
    wr(REG_CTRL, 32'h3);
    $display("test probe done");
    // Retries: silent, low report, accepted report
    for (int i = 0; i < 3; i++) begin
      wait_pwr(1'b1);
      chk("retry freq", {14'h0, switching_frequency_o}, 32'd155000 - 32'd5000 * i);
      if (i == 1) report(8'h3f);
      if (i == 2) report(8'h40);
      if (i < 2) wait_pwr(1'b0);
    end
    repeat (2) @(posedge sys_clk_i);
    rd(REG_STATUS);
    chk("transfer", d & 32'h13, 32'h13);
    $display("test retry done");
    // Loop: duty first, frequency once duty clamps or in frequency mode
    samp(16'd600, 32'd145000, 32'd2990);
    samp(16'd400, 32'd145000, 32'd3000);
    samp(16'd25500, 32'd145000, 32'd1000);
    samp(16'd25500, 32'd165000, 32'd200);
    wr(REG_CTRL, 32'h5);
    samp(16'd505, 32'd165005, 32'd200);
    samp(16'd20500, 32'd185005, 32'd200);
    samp(16'd20500, 32'd205000, 32'd200);
    rchk("current", REG_CURRENT, 32'd20500);
    rchk("freq", REG_FREQ, 32'd205000);
    rchk("duty", REG_DUTY, 32'd200);
    rd(REG_STATUS);
    chk("clamp flags", d & 32'h60, 32'h60);
    chk("overlap", {31'h0, overlap}, 32'h0);
    $display("test loop done");
    // End of transfer: power drops, then a fresh probe at the start values
    @(posedge sys_clk_i);
    end_transfer_i <= 1'b1;
    @(posedge sys_clk_i);
    end_transfer_i <= 1'b0;
    wait_pwr(1'b0);
    wait_pwr(1'b1);
    chk("restart freq", {14'h0, switching_frequency_o}, 32'd155000);
    chk("restart duty", {19'h0, duty_cycle_o}, 32'd3000);
    rd(REG_STATUS);
    chk("restart", d & 32'hf73, 32'h101);
    $display("test end transfer done");
    conclude();
  end
endmodule // itpc_tb_top
